// ### pkg/cirp_defs.vh
// constants for the core interrupt, reset-cause and pc block
// assumes a 32-bit axi4-lite register bus, byte address = 4 * index
`ifndef CIRP_DEFS_VH
`define CIRP_DEFS_VH
// ------------------------------------------------------------
// register indexes (byte address is four times the index)
// ------------------------------------------------------------
`define CIRP_IDX_PCLOW 10'h002
`define CIRP_IDX_PCLOW_B1 10'h082
`define CIRP_IDX_PCHI 10'h00a
`define CIRP_IDX_PCHI_B1 10'h08a
`define CIRP_IDX_INTCTL 10'h00b
`define CIRP_IDX_INTCTL_B1 10'h08b
`define CIRP_IDX_PFLAG 10'h00c
`define CIRP_IDX_PEN 10'h08c
`define CIRP_IDX_RSTCAUSE 10'h08e
`define CIRP_IDX_EDGESEL 10'h081
`define CIRP_IDX_PCMON 10'h0f0
// ------------------------------------------------------------
// register select codes
// ------------------------------------------------------------
`define CIRP_SEL_NONE 3'h0
`define CIRP_SEL_PCLOW 3'h1
`define CIRP_SEL_PCHI 3'h2
`define CIRP_SEL_INTCTL 3'h3
`define CIRP_SEL_PFLAG 3'h4
`define CIRP_SEL_PEN 3'h5
`define CIRP_SEL_RSTCAUSE 3'h6
`define CIRP_SEL_EDGESEL 3'h7
`define CIRP_SEL_PCMON 4'h8
// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define CIRP_GIE 7
`define CIRP_PERIPH_INT_ENABLE 6
`define CIRP_TOVF_IE 5
`define CIRP_EXT_IE 4
`define CIRP_PCHG_IE 3
`define CIRP_TOVF_F 2
`define CIRP_EXT_F 1
`define CIRP_PCHG_F 0
`define CIRP_PAR_F 7
`define CIRP_CMP_F 6
`define CIRP_RC_PARCFG 7
`define CIRP_RC_PER 2
`define CIRP_RC_POR 1
`define CIRP_RC_BOR 0
`define CIRP_EDGE_BIT 6
// ------------------------------------------------------------
// reset values and sizes
// ------------------------------------------------------------
`define CIRP_INTCTL_RST 8'h00
`define CIRP_PFLAG_RST 2'h0
`define CIRP_PEN_RST 2'h0
`define CIRP_EDGESEL_RST 1'h1
`define CIRP_PCHI_RST 5'h00
`define CIRP_PC_RST 13'h0000
`define CIRP_STACK_DEPTH 8
`define CIRP_RESP_OKAY 2'h0
`define CIRP_RESP_SLVERR 2'h2
`endif

// ### src/cirp_core_ctl.v
// core interrupt control, reset-cause status, program counter, stack
// assumes core strobes are one-cycle pulses synchronous to clk
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "cirp_defs.vh"
module cirp_core_ctl (
    // clock and reset
    input wire clk,
    input wire arst_n,
    // axi4-lite write address and data
    input wire [11:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // axi4-lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read
    input wire [11:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // interrupt sources
    input wire timerOvfEvt,
    input wire extIntPin,
    input wire portChangeEvt,
    input wire parallelPortEvt,
    input wire comparatorEvt,
    // configuration word and reset causes
    input wire parityCheckCfg,
    input wire brownoutCircuitCfg,
    input wire porEvt,
    input wire borEvt,
    input wire perEvt,
    input wire otherRstEvt,
    // core instruction strobes
    input wire pcIncr,
    input wire jumpInstr,
    input wire callInstr,
    input wire [10:0] jumpTarget,
    input wire returnInstr,
    input wire intBranch,
    input wire [12:0] intVector,
    // core outputs
    output reg [12:0] pcOut,
    output wire [12:0] progAddr,
    output wire intReq
);
    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    // arst_n takes effect at once and leaves two edges later via this pair
    reg rstSync1_q;
    reg rstSync2_q;
    wire rst;
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rstSync1_q <= 1'b0;
            rstSync2_q <= 1'b0;
        end else begin
            rstSync1_q <= 1'b1;
            rstSync2_q <= rstSync1_q;
        end
    end
    assign rst = ~rstSync2_q;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    function [3:0] regSel;
        input [11:0] addr;
        begin
            case (addr[11:2])
                `CIRP_IDX_PCLOW, `CIRP_IDX_PCLOW_B1:
                    regSel = {1'b0, `CIRP_SEL_PCLOW};
                `CIRP_IDX_PCHI, `CIRP_IDX_PCHI_B1:
                    regSel = {1'b0, `CIRP_SEL_PCHI};
                `CIRP_IDX_INTCTL, `CIRP_IDX_INTCTL_B1:
                    regSel = {1'b0, `CIRP_SEL_INTCTL};
                `CIRP_IDX_PFLAG: regSel = {1'b0, `CIRP_SEL_PFLAG};
                `CIRP_IDX_PEN: regSel = {1'b0, `CIRP_SEL_PEN};
                `CIRP_IDX_RSTCAUSE: regSel = {1'b0, `CIRP_SEL_RSTCAUSE};
                `CIRP_IDX_EDGESEL: regSel = {1'b0, `CIRP_SEL_EDGESEL};
                `CIRP_IDX_PCMON: regSel = `CIRP_SEL_PCMON;
                default: regSel = {1'b0, `CIRP_SEL_NONE};
            endcase
        end
    endfunction

    // ------------------------------------------------------------
    // axi write channel
    // ------------------------------------------------------------
    reg awHeld_q;
    reg wHeld_q;
    reg [11:0] awAddr_q;
    reg [7:0] wByte_q;
    reg wLane_q;
    wire wrFire;
    wire [3:0] wrSel;
    wire wrOk;
    // one strobe per register except the pc monitor, high in the cycle its write lands
    wire wrPcLow;
    wire wrPcHi;
    wire wrIntCtl;
    wire wrPFlag;
    wire wrPEn;
    wire wrRstCause;
    wire wrEdgeSel;
    // aw and w are held apart so either may arrive first
    assign s_axi_awready = ~awHeld_q & ~s_axi_bvalid;
    assign s_axi_wready = ~wHeld_q & ~s_axi_bvalid;
    assign wrFire = awHeld_q & wHeld_q & ~s_axi_bvalid;
    assign wrSel = regSel(awAddr_q);
    assign wrOk = wrFire & wLane_q;
    assign wrPcLow = wrOk & (wrSel == {1'b0, `CIRP_SEL_PCLOW});
    assign wrPcHi = wrOk & (wrSel == {1'b0, `CIRP_SEL_PCHI});
    assign wrIntCtl = wrOk & (wrSel == {1'b0, `CIRP_SEL_INTCTL});
    assign wrPFlag = wrOk & (wrSel == {1'b0, `CIRP_SEL_PFLAG});
    assign wrPEn = wrOk & (wrSel == {1'b0, `CIRP_SEL_PEN});
    assign wrRstCause = wrOk & (wrSel == {1'b0, `CIRP_SEL_RSTCAUSE});
    assign wrEdgeSel = wrOk & (wrSel == {1'b0, `CIRP_SEL_EDGESEL});
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            awAddr_q <= 12'h000;
            wByte_q <= 8'h00;
            wLane_q <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `CIRP_RESP_OKAY;
        end else if (rst) begin
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            s_axi_bvalid <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_q <= 1'b1;
                awAddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_q <= 1'b1;
                wByte_q <= s_axi_wdata[7:0];
                wLane_q <= s_axi_wstrb[0];
            end
            if (wrFire) begin
                awHeld_q <= 1'b0;
                wHeld_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wrSel == {1'b0, `CIRP_SEL_NONE}) ?
                    `CIRP_RESP_SLVERR : `CIRP_RESP_OKAY;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // interrupt control and flags
    // ------------------------------------------------------------
    reg [7:0] intCtl_q;
    reg [1:0] pFlag_q;
    reg [1:0] pEn_q;
    reg edgeSel_q;
    reg extPinPrev_q;
    wire extEdge;
    wire [7:0] intEvt;
    wire [1:0] pEvt;
    assign extEdge = edgeSel_q ? (extIntPin & ~extPinPrev_q)
                               : (~extIntPin & extPinPrev_q);
    // enables in bits 7..3 are never set by hardware
    assign intEvt = {5'h00, timerOvfEvt, extEdge, portChangeEvt};
    assign pEvt = {parallelPortEvt, comparatorEvt};
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            intCtl_q <= `CIRP_INTCTL_RST;
            pFlag_q <= `CIRP_PFLAG_RST;
            pEn_q <= `CIRP_PEN_RST;
            edgeSel_q <= `CIRP_EDGESEL_RST;
            extPinPrev_q <= 1'b0;
        end else if (rst) begin
            intCtl_q <= `CIRP_INTCTL_RST;
            pFlag_q <= `CIRP_PFLAG_RST;
            pEn_q <= `CIRP_PEN_RST;
            edgeSel_q <= `CIRP_EDGESEL_RST;
            extPinPrev_q <= extIntPin;
        end else begin
            extPinPrev_q <= extIntPin;
            // an event in the clearing cycle wins over the write
            if (wrIntCtl)
                intCtl_q <= wByte_q | intEvt;
            else
                intCtl_q <= intCtl_q | intEvt;
            if (wrPFlag)
                pFlag_q <= wByte_q[7:6] | pEvt;
            else
                pFlag_q <= pFlag_q | pEvt;
            if (wrPEn)
                pEn_q <= wByte_q[7:6];
            if (wrEdgeSel)
                edgeSel_q <= wByte_q[`CIRP_EDGE_BIT];
        end
    end
    assign intReq = intCtl_q[`CIRP_GIE] & (
        (intCtl_q[`CIRP_TOVF_IE] & intCtl_q[`CIRP_TOVF_F]) |
        (intCtl_q[`CIRP_EXT_IE] & intCtl_q[`CIRP_EXT_F]) |
        (intCtl_q[`CIRP_PCHG_IE] & intCtl_q[`CIRP_PCHG_F]) |
        (intCtl_q[`CIRP_PERIPH_INT_ENABLE] & |(pEn_q & pFlag_q)));

    // ------------------------------------------------------------
    // reset-cause status
    // ------------------------------------------------------------
    reg perOk_q;
    reg porOk_q;
    reg borOk_q;
    reg parCfg_q;
    wire [7:0] rstCause;
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            perOk_q <= 1'b1;
            porOk_q <= 1'b0;
            borOk_q <= 1'b0;
            parCfg_q <= 1'b0;
        end else begin
            parCfg_q <= parityCheckCfg;
            if (perEvt)
                perOk_q <= 1'b0;
            else if (wrRstCause)
                perOk_q <= wByte_q[`CIRP_RC_PER];
            if (porEvt)
                porOk_q <= 1'b0;
            else if (wrRstCause)
                porOk_q <= wByte_q[`CIRP_RC_POR];
            // a disabled circuit leaves the bit to software alone
            if (borEvt && brownoutCircuitCfg)
                borOk_q <= 1'b0;
            else if (wrRstCause)
                borOk_q <= wByte_q[`CIRP_RC_BOR];
        end
    end
    assign rstCause = {parCfg_q, 4'h0, perOk_q, porOk_q, borOk_q};

    // ------------------------------------------------------------
    // program counter and return stack
    // ------------------------------------------------------------
    reg [4:0] pcHi_q;
    reg [12:0] stack_q [0:`CIRP_STACK_DEPTH-1];
    reg [2:0] sp_q;
    wire anyRst;
    wire push;
    wire [2:0] spDec;
    assign anyRst = porEvt | borEvt | perEvt | otherRstEvt;
    assign push = ~anyRst & (intBranch | callInstr);
    // a pop reads the entry below the pointer; nothing marks underflow
    assign spDec = sp_q - 3'h1;
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pcOut <= `CIRP_PC_RST;
            pcHi_q <= `CIRP_PCHI_RST;
            sp_q <= 3'h0;
        end else if (rst || anyRst) begin
            pcOut <= `CIRP_PC_RST;
            pcHi_q <= `CIRP_PCHI_RST;
            sp_q <= 3'h0;
        end else begin
            if (wrPcHi)
                pcHi_q <= wByte_q[4:0];
            if (intBranch) begin
                pcOut <= intVector;
                sp_q <= sp_q + 3'h1;
            end else if (callInstr || jumpInstr) begin
                pcOut <= {pcHi_q[4:3], jumpTarget};
                if (callInstr)
                    sp_q <= sp_q + 3'h1;
            end else if (returnInstr) begin
                pcOut <= stack_q[spDec];
                sp_q <= spDec;
            end else if (wrPcLow) begin
                pcOut <= {pcHi_q, wByte_q};
            end else if (pcIncr) begin
                pcOut <= pcOut + 13'h0001;
            end
        end
    end
    // entries survive rst and the reset-cause events; only arst_n clears them, and every reset returns the pointer to zero
    genvar gi;
    generate
        for (gi = 0; gi < `CIRP_STACK_DEPTH; gi = gi + 1) begin : gStack
            always @(posedge clk or negedge arst_n) begin
                if (!arst_n)
                    stack_q[gi] <= `CIRP_PC_RST;
                else if (push && !rst && sp_q == gi)
                    stack_q[gi] <= pcOut;
            end
        end
    endgenerate
    // latch bit 4 may reach pc[12] but never the program address
    assign progAddr = {1'b0, pcOut[11:0]};

    // ------------------------------------------------------------
    // axi read channel
    // ------------------------------------------------------------
    wire [3:0] rdSel;
    reg [7:0] rdByte;
    reg [12:0] rdWide;
    assign s_axi_arready = ~s_axi_rvalid;
    // unmapped reads return zero data with an error response
    assign rdSel = regSel(s_axi_araddr);
    always @* begin
        rdByte = 8'h00;
        rdWide = 13'h0000;
        case (rdSel)
            {1'b0, `CIRP_SEL_PCLOW}: rdByte = pcOut[7:0];
            {1'b0, `CIRP_SEL_PCHI}: rdByte = {3'h0, pcHi_q};
            {1'b0, `CIRP_SEL_INTCTL}: rdByte = intCtl_q;
            {1'b0, `CIRP_SEL_PFLAG}: rdByte = {pFlag_q, 6'h00};
            {1'b0, `CIRP_SEL_PEN}: rdByte = {pEn_q, 6'h00};
            {1'b0, `CIRP_SEL_RSTCAUSE}: rdByte = rstCause;
            {1'b0, `CIRP_SEL_EDGESEL}:
                rdByte = {1'b0, edgeSel_q, 6'h00};
            `CIRP_SEL_PCMON: rdWide = pcOut;
            default: rdByte = 8'h00;
        endcase
    end
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `CIRP_RESP_OKAY;
        end else if (rst) begin
            s_axi_rvalid <= 1'b0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {19'h00000, rdWide | {5'h00, rdByte}};
            s_axi_rresp <= (rdSel == {1'b0, `CIRP_SEL_NONE}) ?
                `CIRP_RESP_SLVERR : `CIRP_RESP_OKAY;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule // cirp_core_ctl

// ### tb/cirp_chk.sv
// checker: pc, stack and bus handshake relations of cirp_core_ctl
// assumes it sees only the top ports; bound at the foot of this file
`timescale 1ns/1ns
module cirp_chk (
    // clock and reset
    input wire clk,
    input wire arst_n,
    // register bus
    input wire s_axi_awready,
    input wire s_axi_bvalid,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    // reset causes and core strobes
    input wire porEvt,
    input wire borEvt,
    input wire perEvt,
    input wire otherRstEvt,
    input wire pcIncr,
    input wire jumpInstr,
    input wire callInstr,
    input wire [10:0] jumpTarget,
    input wire returnInstr,
    input wire intBranch,
    input wire [12:0] intVector,
    // core outputs
    input wire [12:0] pcOut,
    input wire [12:0] progAddr
);
    default clocking dc @(posedge clk); endclocking
    default disable iff (!arst_n);
    wire rc = porEvt | borEvt | perEvt | otherRstEvt;
    wire hi = rc | intBranch;
    wire jc = hi | jumpInstr | callInstr;
    a_rst_pc: assert property (rc |=> pcOut == 13'h0000)
        else $error("pc not cleared");
    a_jump_tgt: assert property (jumpInstr && !hi |=>
        pcOut[10:0] == $past(jumpTarget)) else $error("jump target lost");
    a_int_vec: assert property (intBranch && !rc |=>
        pcOut == $past(intVector)) else $error("vector not loaded");
    a_call_back: assert property (callInstr && !hi ##1
        returnInstr && !jc |=> pcOut == $past(pcOut, 2))
        else $error("return address lost");
    a_pc_step: assert property (pcIncr && !jc && !returnInstr |=>
        pcOut == $past(pcOut) + 13'h1 || $rose(s_axi_bvalid))
        else $error("pc did not step");
    a_page_bit: assert property (progAddr == {1'b0, pcOut[11:0]})
        else $error("bit 12 reached address");
    a_rd_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid) else $error("read not answered");
    a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while busy");
    a_b_block: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("write taken while busy");
    c_call_back: cover property (callInstr ##1 returnInstr);
    c_int: cover property (intBranch);
    c_rst: cover property (rc);
endmodule // cirp_chk
bind cirp_core_ctl cirp_chk chk (.clk, .arst_n, .s_axi_awready,
    .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .porEvt,
    .borEvt, .perEvt, .otherRstEvt, .pcIncr, .jumpInstr, .callInstr,
    .jumpTarget, .returnInstr, .intBranch, .intVector, .pcOut, .progAddr);

// ### tb/cirp_core_model.sv
// instruction core model: one strobe kind per clock, held until the next
// assumes the caller chains op calls and ends a burst with an idle op
`timescale 1ns/1ns
module cirp_core_model (
    // clock
    input wire clk,
    // strobes to the block
    output reg pcIncr = 1'b0,
    output reg jumpInstr = 1'b0,
    output reg callInstr = 1'b0,
    output reg [10:0] jumpTarget = 11'h000,
    output reg returnInstr = 1'b0,
    output reg intBranch = 1'b0,
    output reg [12:0] intVector = 13'h0000
);
    // k: 0 idle, 1 step, 2 jump, 3 call, 4 return, 5 interrupt
    task op(input [2:0] k, input [12:0] a);
        begin
            @(posedge clk);
            pcIncr <= k == 3'h1;
            jumpInstr <= k == 3'h2;
            callInstr <= k == 3'h3;
            returnInstr <= k == 3'h4;
            intBranch <= k == 3'h5;
            jumpTarget <= a[10:0];
            intVector <= a;
        end
    endtask
endmodule // cirp_core_model

// ### tb/cirp_core_ctl_tb.sv
// testbench for cirp_core_ctl with a reference model of pc and stack
// assumes the checker is bound and cirp_core_model drives the strobes
`timescale 1ns/1ns
`include "cirp_defs.vh"
module cirp_core_ctl_tb;
    localparam [1:0] OK = `CIRP_RESP_OKAY;
    localparam [1:0] SE = `CIRP_RESP_SLVERR;
    reg clk, arst_n, extIntPin, parityCheckCfg, brownoutCircuitCfg;
    reg s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    reg s_axi_arvalid, s_axi_rready;
    reg [11:0] s_axi_awaddr, s_axi_araddr;
    reg [31:0] s_axi_wdata;
    reg [3:0] s_axi_wstrb, strb, ev, rs;
    reg [12:0] rnd;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire s_axi_rvalid, intReq, pcIncr, jumpInstr, callInstr;
    wire returnInstr, intBranch;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [12:0] pcOut, progAddr, intVector;
    wire [10:0] jumpTarget;
    integer error_cnt, checks_done, cyc, seed, mpc, sp, lat, i;
    integer stk [0:7];
    cirp_core_ctl uut (.clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .timerOvfEvt(ev[0]),
        .extIntPin, .portChangeEvt(ev[1]), .parallelPortEvt(ev[2]),
        .comparatorEvt(ev[3]), .parityCheckCfg, .brownoutCircuitCfg,
        .porEvt(rs[1]), .borEvt(rs[0]), .perEvt(rs[2]),
        .otherRstEvt(rs[3]), .pcIncr, .jumpInstr, .callInstr, .jumpTarget,
        .returnInstr, .intBranch, .intVector, .pcOut, .progAddr, .intReq);
    cirp_core_model core (.clk, .pcIncr, .jumpInstr, .callInstr,
        .jumpTarget, .returnInstr, .intBranch, .intVector);
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc > 20000) begin
            error_cnt = error_cnt + 1;
            summarize;
        end
    end
    task summarize;
        begin
            $display("checks %0d errors %0d", checks_done, error_cnt);
            if (error_cnt == 0 && checks_done > 0) begin
                $display("Result: passed");
            end else begin
                $display("Result: failed");
            end
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("BAD %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [9:0] a, input [7:0] d, input [1:0] r);
        begin
            @(posedge clk);
            s_axi_awaddr <= {a, 2'b00};
            s_axi_wdata <= {24'h000000, d};
            s_axi_wstrb <= strb;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
            do begin
                @(posedge clk);
                if (s_axi_awready) s_axi_awvalid <= 1'b0;
                if (s_axi_wready) s_axi_wvalid <= 1'b0;
            end while (!s_axi_bvalid);
            s_axi_bready <= 1'b0;
            chk(s_axi_bresp, r);
        end
    endtask
    task rd(input [9:0] a, input [31:0] e, input [1:0] r);
        begin
            @(posedge clk);
            s_axi_araddr <= {a, 2'b00};
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
            do begin
                @(posedge clk);
                if (s_axi_arready) s_axi_arvalid <= 1'b0;
            end while (!s_axi_rvalid);
            s_axi_rready <= 1'b0;
            chk(s_axi_rdata, e);
            chk(s_axi_rresp, r);
        end
    endtask
    // checks the previous op's effect, then steps the reference model
    task cop(input [2:0] k, input [12:0] a);
        begin
            core.op(k, a);
            #1;
            chk(pcOut, mpc);
            if (k == 3'h3 || k == 3'h5) begin
                stk[sp] = mpc;
                sp = (sp + 1) % 8;
            end
            if (k == 3'h4) begin
                sp = (sp + 7) % 8;
                mpc = stk[sp];
            end
            if (k == 3'h1) mpc = (mpc + 1) % 8192;
            if (k == 3'h2 || k == 3'h3) mpc = lat / 8 % 4 * 2048 + a % 2048;
            if (k == 3'h5) mpc = a;
        end
    endtask
    task pul(input [3:0] e, input [3:0] r);
        begin
            @(posedge clk);
            ev <= e;
            rs <= r;
            @(posedge clk);
            ev <= 4'h0;
            rs <= 4'h0;
            if (r != 4'h0) begin
                mpc = 0;
                sp = 0;
                lat = 0;
            end
        end
    endtask
    initial begin
        error_cnt = 0;
        checks_done = 0;
        cyc = 0;
        seed = 27;
        mpc = 0;
        sp = 0;
        lat = 0;
        arst_n = 1'b0;
        extIntPin = 1'b0;
        parityCheckCfg = 1'b1;
        brownoutCircuitCfg = 1'b1;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready} = 2'h0;
        s_axi_awaddr = 12'h000;
        s_axi_araddr = 12'h000;
        s_axi_wdata = 32'h00000000;
        s_axi_wstrb = 4'hf;
        strb = 4'hf;
        ev = 4'h0;
        rs = 4'h0;
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd(10'h00b, 32'h00, OK);
        rd(10'h00c, 32'h00, OK);
        rd(10'h08c, 32'h00, OK);
        rd(10'h08e, 32'h84, OK);
        rd(10'h081, 32'h40, OK);
        rd(10'h010, 32'h00, SE);
        wr(10'h010, 8'hff, SE);
        strb = 4'he;
        wr(10'h00b, 8'hff, OK);
        strb = 4'hf;
        rd(10'h00b, 32'h00, OK);
        pul(4'h1, 4'h0);
        rd(10'h00b, 32'h04, OK);
        rd(10'h08b, 32'h04, OK);
        chk(intReq, 1'b0);
        wr(10'h00b, 8'ha4, OK);
        chk(intReq, 1'b1);
        wr(10'h00b, 8'h80, OK);
        chk(intReq, 1'b0);
        pul(4'h2, 4'h0);
        @(posedge clk);
        extIntPin <= 1'b1;
        rd(10'h00b, 32'h83, OK);
        wr(10'h081, 8'h00, OK);
        wr(10'h00b, 8'h80, OK);
        @(posedge clk);
        extIntPin <= 1'b0;
        rd(10'h00b, 32'h82, OK);
        pul(4'hc, 4'h0);
        rd(10'h00c, 32'hc0, OK);
        wr(10'h08c, 8'hc0, OK);
        chk(intReq, 1'b0);
        wr(10'h00b, 8'hc0, OK);
        chk(intReq, 1'b1);
        wr(10'h00c, 8'h00, OK);
        chk(intReq, 1'b0);
        for (i = 0; i < 4; i = i + 1) begin
            wr(10'h08e, 8'hff, OK);
            cop(3'h1, 13'h0000);
            cop(3'h0, 13'h0000);
            pul(4'h0, 4'h1 << i);
            cop(3'h0, 13'h0000);
            rd(10'h08e, 32'h87 & ~(32'h1 << i), OK);
        end
        @(posedge clk);
        parityCheckCfg <= 1'b0;
        brownoutCircuitCfg <= 1'b0;
        wr(10'h08e, 8'hff, OK);
        pul(4'h0, 4'h1);
        rd(10'h08e, 32'h07, OK);
        lat = 31;
        rnd = $random(seed);
        wr(10'h00a, 8'h1f, OK);
        wr(10'h002, rnd[7:0], OK);
        mpc = lat * 256 + rnd % 256;
        cop(3'h0, 13'h0000);
        chk(progAddr, mpc % 4096);
        rd(10'h002, rnd % 256, OK);
        lat = 2;
        wr(10'h00a, 8'h02, OK);
        wr(10'h002, 8'hff, OK);
        mpc = lat * 256 + 255;
        cop(3'h1, 13'h0000);
        cop(3'h0, 13'h0000);
        rd(10'h00a, lat, OK);
        for (i = 0; i < 4; i = i + 1) begin
            lat = i * 8;
            wr(10'h00a, lat[7:0], OK);
            rnd = $random(seed);
            cop(3'h2, rnd);
            cop(3'h0, 13'h0000);
        end
        rnd = $random(seed);
        cop(3'h3, rnd);
        cop(3'h4, 13'h0000);
        for (i = 0; i < 10; i = i + 1) begin
            rnd = $random(seed);
            cop(3'h3, rnd);
            cop(3'h1, 13'h0000);
        end
        rnd = $random(seed);
        cop(3'h5, rnd);
        for (i = 0; i < 11; i = i + 1) cop(3'h4, 13'h0000);
        cop(3'h0, 13'h0000);
        rd(10'h00a, lat, OK);
        summarize;
    end
endmodule // cirp_core_ctl_tb
